// *** pkg/els_caps_pkg.sv ***
// Constants and carrier types for the node capabilities and recovery qualifier responder
package els_caps_pkg;

    localparam logic [7:0] code_node_caps = 8'h53;
    localparam logic [7:0] code_rrq = 8'h12;
    localparam logic [7:0] code_accept = 8'h02;
    localparam logic [7:0] code_reject = 8'h01;
    localparam logic [7:0] rjt_reason_logical = 8'h03;
    localparam logic [7:0] rjt_expl_none = 8'h2a;

    localparam logic [15:0] min_req_len = 16'h0010;
    localparam logic [15:0] max_req_len = 16'h0100;
    localparam logic [15:0] max_acc_len = 16'h0100;
    localparam logic [7:0] max_vendor_info_len = 8'h80;

    // Byte positions inside the request / accept payload
    localparam logic [8:0] pos_code = 9'h000;
    localparam logic [8:0] pos_len_hi = 9'h002;
    localparam logic [8:0] pos_len_lo = 9'h003;
    localparam logic [8:0] pos_flags = 9'h004;
    localparam logic [8:0] pos_vendor_info_length = 9'h007;
    localparam logic [8:0] pos_vendor_id = 9'h008;
    localparam logic [8:0] pos_entries = 9'h010;

    // Bit positions in the request flags and capability entry flags
    localparam int select_bit = 7;
    localparam int invalidate_bit = 7;
    localparam int extended_bit = 6;
    localparam int id_kind_hi = 5;
    localparam int id_kind_lo = 4;
    localparam int entry_bytes = 4;

    localparam logic [1:0] kind_standard = 2'h0;
    localparam logic [1:0] kind_vendor = 2'h1;
    localparam logic [1:0] kind_receiver_vendor = 2'h2;

    // Supported standard document identifiers, reported in this order
    localparam int num_docs = 4;
    localparam logic [31:0] supported_docs = 32'h04_13_25_26;
    localparam logic [7:0] rev_low = 8'h00;
    localparam logic [7:0] rev_high = 8'h0a;

    localparam logic [31:0] rrq_accept_word = 32'h02000000;

    localparam int buf_depth = 2;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } byte_beat_s;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] doc_id;
        logic [7:0] low_rev;
        logic [7:0] high_rev;
    } cap_entry_s;

    typedef enum logic [4:0] {
        st_idle = 5'b00001,
        st_parse = 5'b00010,
        st_drain = 5'b00100,
        st_send = 5'b01000,
        st_done = 5'b10000
    } resp_state_e;

    typedef enum logic [2:0] {
        resp_caps_acc = 3'b001,
        resp_caps_rjt = 3'b010,
        resp_rrq_acc = 3'b100
    } resp_kind_e;

endpackage

// *** design/resp_skid_buffer.sv ***
// Two-entry valid/ready buffer in the response byte path
module resp_skid_buffer #(
    parameter int width = 9,
    parameter int depth = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [width-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [width-1:0] out_data
);
    localparam int aw = (depth > 1) ? $clog2(depth) : 1;

    logic [width-1:0] mem [depth];
    logic [aw-1:0] wr_ptr;
    logic [aw-1:0] rd_ptr;
    logic [aw:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (aw+1)'(depth));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == aw'(depth - 1)) ? '0 : aw'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == aw'(depth - 1)) ? '0 : aw'(rd_ptr + 1'b1);
            end
            count <= (aw+1)'(count + (aw+1)'(push) - (aw+1)'(pop));
        end
    end
endmodule

// *** design/els_caps_responder.sv ***
// Node capabilities and recovery qualifier request parser and response builder
//
// Overview of operation
// RULE1: Request code 53h in byte 0; accept carries 02h there, same layout.
// RULE2: Requester gives a two-byte length, 16 to 256 bytes.
// RULE3: Accept payload never exceeds 256 bytes.
// RULE4: Select flag set gives reject, reason 03h, explanation 2Ah.
// RULE5: Accept lists every supported capability entry.
// RULE6: Vendor information length is one byte; up to 128 supported.
// RULE7: Bytes 8 to 15 carry an eight-byte ASCII vendor identifier.
// RULE8: Entry extended bit 6 clear means 4 bytes, set adds extension length.
// RULE9: Invalidate-previous bit of an entry is ignored.
// RULE10: Entry bits 5-4 choose standard, vendor, receiver-vendor or reserved identifier.
// RULE11: Preference bits 1-0 are ignored.
// RULE12: Only 04h, 13h, 25h, 26h standard identifiers are reported supported.
// RULE13: Low and high revision bytes encode tenths from 0.0 to 25.5.
// RULE14: Extension length counts itself, the reserved field and extension bytes.
// RULE15: Every returned entry is 4 bytes, no extension.
// RULE16: Recovery qualifier request carries 12000000h, source id, exchange ids.
// RULE17: Byte 0 of 12h always gets a recovery qualifier accept, unchecked.
// RULE18: Recovery qualifier accept is one word 02000000h.
// RULE19: Recovery qualifier is reusable at once after an exchange abort.
// RULE20: Parse in arrival order; decide after the flags byte, then respond.
module els_caps_responder #(
    parameter logic [63:0] vendor_id = 64'h5645_4e44_4f52_2020,  // Arbitrary ASCII value
    parameter int depth = els_caps_pkg::buf_depth
) (
    input wire logic clk,
    input wire logic reset,
    // Request stream from frame logic
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_data,
    input wire logic req_last,
    // Response stream to frame logic
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [7:0] rsp_data,
    output logic rsp_last,
    // Status
    output logic busy,
    output logic last_rejected,
    output logic length_error,
    output logic qualifier_reusable,
    output logic [7:0] entries_seen,
    output logic [7:0] supported_seen
);
    localparam int n = els_caps_pkg::num_docs;
    localparam logic [15:0] acc_len = 16'(els_caps_pkg::pos_entries) + 16'(n * els_caps_pkg::entry_bytes);

    els_caps_pkg::resp_state_e state;
    els_caps_pkg::resp_kind_e kind;
    logic [8:0] idx;
    logic [8:0] out_idx;
    logic [15:0] req_len;
    logic [7:0] req_flags;
    logic [7:0] vendor_info_length;
    logic [15:0] entry_left;
    logic [15:0] ext_len;
    logic [2:0] entry_pos;
    logic [7:0] entry_flags;
    els_caps_pkg::cap_entry_s cur_entry;
    logic [8:0] rsp_len;
    logic take;
    logic [8:0] beat_in;
    logic buf_ready;
    logic [8:0] buf_out;
    logic next_beat_last;
    logic [7:0] next_beat_data;

    // RULE12
    function automatic logic doc_supported(input logic [1:0] id_kind, input logic [7:0] id);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (id == els_caps_pkg::supported_docs[8*i +: 8]) begin
                hit = 1'b1;
            end
        end
        return (id_kind == els_caps_pkg::kind_standard) && hit;
    endfunction

    assign req_ready = (state == els_caps_pkg::st_parse) || (state == els_caps_pkg::st_drain);
    assign take = req_valid && req_ready;
    assign busy = (state != els_caps_pkg::st_idle);

    ////////////////////////////////////////////////////////////////////////////////
    // Control sequence

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= els_caps_pkg::st_idle;
            kind <= els_caps_pkg::resp_caps_acc;
        end else begin
            case (state)
                els_caps_pkg::st_idle: begin
                    state <= els_caps_pkg::st_parse;
                end
                els_caps_pkg::st_parse: begin
                    if (take && idx == els_caps_pkg::pos_code) begin
                        if (req_data == els_caps_pkg::code_rrq) begin  // RULE17
                            kind <= els_caps_pkg::resp_rrq_acc;
                            state <= req_last ? els_caps_pkg::st_send : els_caps_pkg::st_drain;
                        end else if (req_data != els_caps_pkg::code_node_caps) begin
                            // Unknown codes belong to other services; swallow them
                            kind <= els_caps_pkg::resp_caps_acc;
                            state <= req_last ? els_caps_pkg::st_idle : els_caps_pkg::st_drain;
                        end else begin
                            // Set kind now so the length bytes are captured after a recovery request
                            kind <= els_caps_pkg::resp_caps_acc;
                            if (req_last) begin
                                state <= els_caps_pkg::st_idle;
                            end
                        end
                    end else if (take && idx == els_caps_pkg::pos_flags) begin
                        // RULE20
                        kind <= req_data[els_caps_pkg::select_bit] ? els_caps_pkg::resp_caps_rjt
                                                                   : els_caps_pkg::resp_caps_acc;  // RULE4
                        state <= req_last ? els_caps_pkg::st_send : els_caps_pkg::st_drain;
                    end else if (take && req_last) begin
                        state <= els_caps_pkg::st_idle;
                    end
                end
                els_caps_pkg::st_drain: begin
                    if (take && req_last) begin
                        state <= (kind == els_caps_pkg::resp_caps_acc && idx <= els_caps_pkg::pos_code)
                                 ? els_caps_pkg::st_idle : els_caps_pkg::st_send;
                    end
                end
                els_caps_pkg::st_send: begin
                    if (buf_ready && next_beat_last) begin
                        state <= els_caps_pkg::st_done;
                    end
                end
                els_caps_pkg::st_done: begin
                    state <= els_caps_pkg::st_idle;
                end
                default: begin
                    state <= els_caps_pkg::st_idle;
                end
            endcase
        end
    end

    // Byte index of the request; an unknown code pins idx at 0 so drain ends quietly
    always_ff @(posedge clk) begin
        if (reset || state == els_caps_pkg::st_idle) begin
            idx <= '0;
        end else if (take && idx != 9'h1ff) begin
            idx <= (idx == els_caps_pkg::pos_code && (state == els_caps_pkg::st_drain
                    || (req_data != els_caps_pkg::code_node_caps && req_data != els_caps_pkg::code_rrq)))
                   ? 9'h000 : 9'(idx + 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Header fields, parsed in arrival order

    always_ff @(posedge clk) begin
        if (reset) begin
            req_len <= '0;
            req_flags <= '0;
            vendor_info_length <= '0;
        end else if (take && kind != els_caps_pkg::resp_rrq_acc) begin
            if (idx == els_caps_pkg::pos_len_hi) begin
                req_len[15:8] <= req_data;
            end
            if (idx == els_caps_pkg::pos_len_lo) begin
                req_len[7:0] <= req_data;
            end
            if (idx == els_caps_pkg::pos_flags) begin
                req_flags <= req_data;
            end
            if (idx == els_caps_pkg::pos_vendor_info_length) begin
                vendor_info_length <= req_data;  // RULE6
            end
        end
    end

    // RULE2
    always_ff @(posedge clk) begin
        if (reset) begin
            length_error <= 1'b0;
        end else if (state == els_caps_pkg::st_send && kind != els_caps_pkg::resp_rrq_acc) begin
            length_error <= (req_len < els_caps_pkg::min_req_len) || (req_len > els_caps_pkg::max_req_len)
                            || (vendor_info_length > els_caps_pkg::max_vendor_info_len);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Capability entry walk: counts entries and supported standard identifiers

    always_ff @(posedge clk) begin
        if (reset || state == els_caps_pkg::st_idle) begin
            entry_pos <= '0;
            entry_flags <= '0;
            ext_len <= '0;
            entry_left <= '0;
            entries_seen <= '0;
            supported_seen <= '0;
            cur_entry <= '0;
        end else if (take && kind == els_caps_pkg::resp_caps_acc && idx >= els_caps_pkg::pos_entries
                     && 16'(idx) < req_len - 16'(vendor_info_length)) begin
            if (entry_left == '0 && entry_pos == '0) begin
                // Invalidate and preference bits are carried but never acted on
                entry_flags <= req_data;  // RULE9 RULE11
                cur_entry.flags <= req_data;
                entry_pos <= 3'd1;
            end else if (entry_pos == 3'd1) begin
                cur_entry.doc_id <= req_data;
                entry_pos <= 3'd2;
                if (doc_supported(entry_flags[els_caps_pkg::id_kind_hi:els_caps_pkg::id_kind_lo], req_data)) begin
                    supported_seen <= 8'(supported_seen + 1'b1);  // RULE10 RULE12
                end
            end else if (entry_pos == 3'd2) begin
                cur_entry.low_rev <= req_data;  // RULE13
                entry_pos <= 3'd3;
            end else if (entry_pos == 3'd3) begin
                cur_entry.high_rev <= req_data;  // RULE13
                entries_seen <= 8'(entries_seen + 1'b1);
                entry_pos <= entry_flags[els_caps_pkg::extended_bit] ? 3'd4 : 3'd0;  // RULE8
            end else if (entry_pos == 3'd4 || entry_pos == 3'd5) begin
                entry_pos <= 3'(entry_pos + 1'b1);
            end else if (entry_pos == 3'd6) begin
                ext_len[15:8] <= req_data;
                entry_pos <= 3'd7;
            end else if (entry_pos == 3'd7) begin
                // Length counts reserved pair, itself and extension: four already consumed
                entry_left <= ({ext_len[15:8], req_data} > 16'd4) ? 16'({ext_len[15:8], req_data} - 16'd4) : '0;  // RULE14
                entry_pos <= 3'd0;
            end else if (entry_left != '0) begin
                entry_left <= 16'(entry_left - 1'b1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Response builder

    always_ff @(posedge clk) begin
        if (reset) begin
            last_rejected <= 1'b0;
            qualifier_reusable <= 1'b1;
        end else if (state == els_caps_pkg::st_done) begin
            last_rejected <= (kind == els_caps_pkg::resp_caps_rjt);
            qualifier_reusable <= 1'b1;  // RULE19
        end
    end

    always_comb begin
        case (kind)
            els_caps_pkg::resp_rrq_acc: rsp_len = 9'd4;  // RULE18
            els_caps_pkg::resp_caps_rjt: rsp_len = 9'd4;
            default: rsp_len = (acc_len > els_caps_pkg::max_acc_len) ? 9'(els_caps_pkg::max_acc_len) : 9'(acc_len);  // RULE3
        endcase
    end

    always_comb begin
        next_beat_data = 8'h00;
        next_beat_last = (out_idx == 9'(rsp_len - 1'b1));
        case (kind)
            els_caps_pkg::resp_rrq_acc: begin
                next_beat_data = els_caps_pkg::rrq_accept_word[8*(3 - out_idx[1:0]) +: 8];  // RULE18
            end
            els_caps_pkg::resp_caps_rjt: begin
                case (out_idx[1:0])
                    2'd0: next_beat_data = els_caps_pkg::code_reject;
                    2'd2: next_beat_data = els_caps_pkg::rjt_reason_logical;  // RULE4
                    2'd3: next_beat_data = els_caps_pkg::rjt_expl_none;
                    default: next_beat_data = 8'h00;
                endcase
            end
            default: begin
                if (out_idx == els_caps_pkg::pos_code) begin
                    next_beat_data = els_caps_pkg::code_accept;  // RULE1
                end else if (out_idx == els_caps_pkg::pos_len_hi) begin
                    next_beat_data = rsp_len[8] ? 8'h01 : 8'h00;
                end else if (out_idx == els_caps_pkg::pos_len_lo) begin
                    next_beat_data = rsp_len[7:0];
                end else if (out_idx >= els_caps_pkg::pos_vendor_id && out_idx < els_caps_pkg::pos_entries) begin
                    next_beat_data = vendor_id[8*(7 - out_idx[2:0]) +: 8];  // RULE7
                end else if (out_idx >= els_caps_pkg::pos_entries) begin
                    // Plain 4-byte standard entries, one per supported identifier
                    case (out_idx[1:0])
                        2'd0: next_beat_data = 8'h00;  // RULE15
                        2'd1: next_beat_data = els_caps_pkg::supported_docs[8*(n - 1 - 32'(out_idx[7:2] - 6'd4)) +: 8];  // RULE5
                        2'd2: next_beat_data = els_caps_pkg::rev_low;
                        default: next_beat_data = els_caps_pkg::rev_high;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset || state != els_caps_pkg::st_send) begin
            out_idx <= '0;
        end else if (buf_ready) begin
            out_idx <= 9'(out_idx + 1'b1);
        end
    end

    assign beat_in = {next_beat_data, next_beat_last};

    resp_skid_buffer #(
        .width(9),
        .depth(depth)
    ) u_buf (
        .clk(clk),
        .reset(reset),
        .in_valid(state == els_caps_pkg::st_send),
        .in_ready(buf_ready),
        .in_data(beat_in),
        .out_valid(rsp_valid),
        .out_ready(rsp_ready),
        .out_data(buf_out)
    );

    assign rsp_data = buf_out[8:1];
    assign rsp_last = buf_out[0];
endmodule

// *** tb/els_caps_monitor.sv ***
// Concurrent checks on the responder's ports
module els_caps_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last,
    input wire logic qualifier_reusable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] idx;
    logic in_rjt;
    wire hs = rsp_valid && rsp_ready;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////
    // Byte position inside the current response frame
    always_ff @(posedge clk) begin
        if (reset || (hs && rsp_last)) begin
            idx <= 9'h000;
        end else if (hs) begin
            idx <= idx + 9'h001;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            in_rjt <= 1'b0;
        end else if (hs && idx == 9'h000) begin
            in_rjt <= rsp_data == 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////
    a_first_code: assert property (
        hs && idx == 9'h000 |-> rsp_data == 8'h02 || rsp_data == 8'h01)
        else $error("Bad command byte in response");
    a_rjt_reason: assert property (
        hs && in_rjt && idx == 9'h002 |-> rsp_data == 8'h03)
        else $error("Bad reject reason");
    a_rjt_expl: assert property (
        hs && in_rjt && idx == 9'h003 |-> rsp_data == 8'h2a && rsp_last)
        else $error("Bad reject explanation");
    a_frame_len: assert property (
        hs && rsp_last |-> idx == 9'h003 || idx == 9'h01f)
        else $error("Bad response length");
    a_acc_bound: assert property (
        hs |-> idx < 9'h100)
        else $error("Response too long");
    a_len_field: assert property (
        hs && !in_rjt && idx == 9'h003 |-> (rsp_data == 8'h20 && !rsp_last) || (rsp_data == 8'h00 && rsp_last))
        else $error("Bad length byte");
    a_acc_zero: assert property (
        hs && !in_rjt && idx == 9'h001 |-> rsp_data == 8'h00)
        else $error("Bad second accept byte");
    a_rsp_hold: assert property (
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last))
        else $error("Response byte changed while stalled");
    a_start_after: assert property (
        $rose(rsp_valid) |-> !req_ready)
        else $error("Response began while taking request");
    a_qual_reuse: assert property (
        qualifier_reusable)
        else $error("Qualifier not reusable");
endmodule

// *** tb/initiator_model.sv ***
// Initiator-side model: feeds request bytes and drains response bytes
module initiator_model (
    input wire logic clk,
    input wire logic reset,
    output logic req_valid,
    input wire logic req_ready,
    output logic [7:0] req_data,
    output logic req_last,
    input wire logic rsp_valid,
    output logic rsp_ready,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stall = 1'b0;
    logic [1:0] tick = 2'h0;
    logic [8:0] got[$];
    initial begin
        req_valid = 1'b0;
        req_data = 8'h00;
        req_last = 1'b0;
        rsp_ready = 1'b0;
    end
    // Slow mode takes one byte in four so the buffer fills and refuses
    always @(posedge clk) begin
        tick <= tick + 2'h1;
        rsp_ready <= !stall || tick == 2'h0;
    end
    always @(negedge clk) begin
        if (!reset && rsp_valid && rsp_ready) begin
            got.push_back({rsp_last, rsp_data});
        end
    end
    // Bytes go in payload order; released data shows the inverse of the last byte
    task automatic send(input logic [7:0] b[$]);
        logic r;
        @(posedge clk);
        foreach (b[i]) begin
            req_valid <= 1'b1;
            req_data <= b[i];
            req_last <= i == b.size() - 1;
            do begin
                @(negedge clk);
                r = req_ready;
                @(posedge clk);
            end while (!r);
        end
        req_valid <= 1'b0;
        req_data <= ~b[b.size() - 1];
        req_last <= 1'b0;
    endtask
endmodule

// *** tb/els_caps_responder_bench.sv ***
// Self-checking bench for the node capabilities and recovery qualifier responder
module els_caps_responder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] vid = 64'h4142_4344_4546_4748;  // Arbitrary ASCII value
    localparam logic [7:0] docs [4] = '{8'h04, 8'h13, 8'h25, 8'h26};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid, req_ready, req_last, rsp_valid, rsp_ready, rsp_last, busy;
    logic last_rejected, length_error, qualifier_reusable;
    logic [7:0] req_data, rsp_data, entries_seen, supported_seen, ent, sup;
    int err_total = 0;
    int checks_done = 0;
    logic [7:0] rq[$];
    logic [7:0] ex[$];
    always #10 clk = ~clk;
    els_caps_responder #(.vendor_id(vid)) dut (.clk(clk), .reset(reset), .req_valid(req_valid),
        .req_ready(req_ready), .req_data(req_data), .req_last(req_last), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last), .busy(busy),
        .last_rejected(last_rejected), .length_error(length_error),
        .qualifier_reusable(qualifier_reusable), .entries_seen(entries_seen), .supported_seen(supported_seen));
    initiator_model im (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
        .req_data(req_data), .req_last(req_last), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_data(rsp_data), .rsp_last(rsp_last));
    ////////////////////////////////////////////////////////////
    task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_bit(input string what, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic caps_req(input logic [15:0] len, input logic [7:0] flags, input logic [7:0] vil);
        rq = {8'h53, 8'h00, len[15:8], len[7:0], flags, 8'h00, 8'h00, vil};
        for (int i = 0; i < 8; i++) begin
            rq.push_back(8'h30 + 8'(i));
        end
    endtask
    task automatic acc_exp;
        ex = {8'h02, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 7; i >= 0; i--) begin
            ex.push_back(vid[i*8 +: 8]);
        end
        foreach (docs[i]) begin
            ex = {ex, 8'h00, docs[i], els_caps_pkg::rev_low, els_caps_pkg::rev_high};
        end
    endtask
    // Status counters clear once idle, so they are taken early in the reply
    task automatic exchange(input logic slow);
        int n;
        im.got.delete();
        im.stall <= slow;
        im.send(rq);
        repeat (2) @(negedge clk);
        ent = entries_seen;
        sup = supported_seen;
        n = 0;
        while (im.got.size() < ex.size() && n < 400) begin
            @(posedge clk);
            n++;
        end
        repeat (ex.size() == 0 ? 40 : 6) @(posedge clk);
        cmp_bit("response size", 1'b1, im.got.size() == ex.size());
        foreach (ex[i]) begin
            cmp_byte("response byte", ex[i], im.got[i][7:0]);
            cmp_bit("response last", i == ex.size() - 1, im.got[i][8]);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #400000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        cmp_bit("qualifier reusable", 1'b1, qualifier_reusable);
        cmp_bit("busy", 1'b0, busy);
        rq = {8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h12, 8'h34, 8'hff, 8'hff};
        ex = {8'h02, 8'h00, 8'h00, 8'h00};
        exchange(1'b0);
        rq = {8'h12, 8'hff, 8'hee, 8'hdd};
        exchange(1'b1);
        $display("test rrq done");
        caps_req(16'h0024, 8'h00, 8'h00);
        rq = {rq, 8'h83, 8'h04, 8'h00, 8'h0a, 8'h10, 8'h04, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h0a};
        rq = {rq, 8'h30, 8'h13, 8'h00, 8'h00, 8'h00, 8'h26, 8'h00, 8'h0a};
        acc_exp();
        exchange(1'b1);
        cmp_byte("entries", 8'h05, ent);
        cmp_byte("supported", 8'h02, sup);
        cmp_bit("length error", 1'b0, length_error);
        cmp_bit("rejected", 1'b0, last_rejected);
        caps_req(16'h0020, 8'h00, 8'h02);
        rq = {rq, 8'h40, 8'h13, 8'h00, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h06, 8'haa, 8'hbb};
        rq = {rq, 8'h00, 8'h25, 8'h00, 8'h0a, 8'hde, 8'had};
        exchange(1'b0);
        cmp_byte("entries", 8'h02, ent);
        cmp_byte("supported", 8'h02, sup);
        cmp_bit("length error", 1'b0, length_error);
        $display("test caps accept done");
        caps_req(16'h0010, 8'h80, 8'h00);
        ex = {8'h01, 8'h00, 8'h03, 8'h2a};
        exchange(1'b1);
        cmp_bit("rejected", 1'b1, last_rejected);
        caps_req(16'h0100, 8'h00, 8'h81);
        acc_exp();
        exchange(1'b0);
        cmp_bit("rejected", 1'b0, last_rejected);
        cmp_bit("length error", 1'b1, length_error);
        caps_req(16'h000f, 8'h00, 8'h80);
        exchange(1'b0);
        cmp_bit("length error", 1'b1, length_error);
        $display("test reject and lengths done");
        rq = {8'h21, 8'h00, 8'h00, 8'h04};
        ex.delete();
        exchange(1'b0);
        $display("test unknown code done");
        summarize();
    end
endmodule

bind els_caps_responder els_caps_monitor mon (.clk(clk), .reset(reset), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .qualifier_reusable(qualifier_reusable));
